/* lsd_host_model.sv */
`timescale 1ns/1ps
// ============================================================
// Host side of the register path.
module lsd_host_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    output logic      [7:0] addr_out,
    output logic            wr_out,
    output logic      [7:0] wdata_out,
    output logic            rd_out
);
    initial begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        wr_out = 1'h0;
        rd_out = 1'h0;
    end
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        wdata_out = d;
        wr_out = 1'h1;
        @(negedge clk_in);
        wr_out = 1'h0;
        // Released data shows the inverse so a stale byte cannot pass.
        wdata_out = ~d;
    endtask : put
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        rd_out = 1'h1;
        @(negedge clk_in);
        rd_out = 1'h0;
        @(negedge clk_in);
        d = rdata_in;
    endtask : get
    task automatic save(input logic [7:0] a);
        put(8'hC0, a);
        put(8'hC1, 8'h02);
    endtask : save
endmodule : lsd_host_model

/* lsd_nv_if.sv */
`timescale 1ns/1ps
interface lsd_nv_if;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;

    modport store (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
    modport user  (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
endinterface : lsd_nv_if

/* lsd_nv_store.sv */
`timescale 1ns/1ps
module lsd_nv_store #(
    parameter int unsigned DEPTH = lsd_pkg::CTRL_SPAN
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    lsd_nv_if.store   nv
);
    import lsd_pkg::*;

    logic [7:0] cell_mem [DEPTH];

    if (DEPTH < 1 || DEPTH > 255) begin : g_depth_check
        $error("Depth must lie between 1 and 255.");
    end

    // =========================================================================
    // Storage
    // Reset stands in for factory programming so that simulation starts from a known image.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                cell_mem[i] <= lsd_factory(8'(i));
            end
        end else if (nv.wr_en && nv.wr_addr < 8'(DEPTH)) begin
            cell_mem[nv.wr_addr] <= nv.wr_data;
        end
    end

    assign nv.rd_data = (nv.rd_addr < 8'(DEPTH)) ? cell_mem[nv.rd_addr] : 8'h00;

endmodule : lsd_nv_store

/* lsd_pkg.sv */
package lsd_pkg;

    // =========================================================================
    // Sizes
    localparam int unsigned CTRL_SPAN = 192;

    // =========================================================================
    // Register offsets
    localparam logic [7:0] A_STR_EN_LO    = 8'h00;
    localparam logic [7:0] A_STR_EN_HI    = 8'h01;
    localparam logic [7:0] A_SETUP        = 8'h02;
    localparam logic [7:0] A_FAULT_EN     = 8'h03;
    localparam logic [7:0] A_MASK_LO      = 8'h04;
    localparam logic [7:0] A_MASK_HI      = 8'h05;
    localparam logic [7:0] A_FAULT_SUM    = 8'h06;
    localparam logic [7:0] A_OC_LO        = 8'h07;
    localparam logic [7:0] A_OC_HI        = 8'h08;
    localparam logic [7:0] A_SC_LO        = 8'h09;
    localparam logic [7:0] A_SC_HI        = 8'h0A;
    localparam logic [7:0] A_OSC          = 8'h0F;
    localparam logic [7:0] A_OPT_A        = 8'h10;
    localparam logic [7:0] A_OPT_C        = 8'h12;
    localparam logic [7:0] A_DAC1         = 8'h13;
    localparam logic [7:0] A_DAC2         = 8'h14;
    localparam logic [7:0] A_DAC3         = 8'h15;
    localparam logic [7:0] A_OPT_STATE    = 8'h16;
    localparam logic [7:0] A_GSC_CTRL     = 8'h20;
    localparam logic [7:0] A_GSC_MUL      = 8'h23;
    localparam logic [7:0] A_PHI_CTRL     = 8'h27;
    localparam logic [7:0] A_PHI_MUL      = 8'h2A;
    localparam logic [7:0] A_DIM_A        = 8'h2D;
    localparam logic [7:0] A_DIM_B        = 8'h2E;
    localparam logic [7:0] A_DIM_STATE    = 8'h32;
    localparam logic [7:0] A_PHI_PCNT     = 8'h33;
    localparam logic [7:0] A_GSC_PCNT_LO  = 8'h34;
    localparam logic [7:0] A_GSC_PCNT_HI  = 8'h35;
    localparam logic [7:0] A_STRSET_FIRST = 8'h40;
    localparam logic [7:0] A_DUTY_FIRST   = 8'h60;
    localparam logic [7:0] A_CTRL_LAST    = 8'hBF;
    localparam logic [7:0] A_NV_PTR       = 8'hC0;
    localparam logic [7:0] A_NV_CMD       = 8'hC1;

    // =========================================================================
    // Field positions and masks
    localparam int unsigned DIM_ENGINE_BIT = 0;
    localparam int unsigned DIM_PASS_BIT   = 1;
    localparam int unsigned OPT_EN_BIT     = 0;
    localparam int unsigned NV_BUSY_BIT    = 7;
    localparam int unsigned NV_BOOT_BIT    = 6;
    localparam int unsigned NV_ERR_BIT     = 5;
    localparam logic [7:0]  FAULT_SUM_MASK = 8'h9F;

    // =========================================================================
    // Nonvolatile commands
    localparam logic [2:0] NV_CMD_LOAD  = 3'h1;
    localparam logic [2:0] NV_CMD_STORE = 3'h2;
    localparam logic [2:0] NV_CMD_BOOT  = 3'h3;

    // =========================================================================
    // Factory image values
    localparam logic [7:0] RST_STR_EN   = 8'hFF;
    localparam logic [7:0] RST_SETUP    = 8'h0D;
    localparam logic [7:0] RST_FAULT_EN = 8'h27;
    localparam logic [7:0] RST_MASK     = 8'hFF;
    localparam logic [7:0] RST_OSC      = 8'h04;
    localparam logic [7:0] RST_OPT_A    = 8'h49;

    typedef enum {LSD_IDLE, LSD_BOOT} lsd_state_t;

    function automatic logic [7:0] lsd_factory(input logic [7:0] a);
        case (a)
            A_STR_EN_LO, A_STR_EN_HI: lsd_factory = RST_STR_EN;
            A_SETUP:                  lsd_factory = RST_SETUP;
            A_FAULT_EN:               lsd_factory = RST_FAULT_EN;
            A_MASK_LO, A_MASK_HI:     lsd_factory = RST_MASK;
            A_OSC:                    lsd_factory = RST_OSC;
            A_OPT_A:                  lsd_factory = RST_OPT_A;
            default:                  lsd_factory = 8'h00;
        endcase
    endfunction : lsd_factory

    // Writable bits per address; zero for gaps and read-only places.
    function automatic logic [7:0] lsd_wmask(input logic [7:0] a);
        if (a >= A_STRSET_FIRST && a <= A_CTRL_LAST) begin
            if (!a[0])
                lsd_wmask = 8'hFF;
            else if (a < A_DUTY_FIRST)
                lsd_wmask = 8'hCF;
            else
                lsd_wmask = 8'h0F;
        end else begin
            case (a)
                A_STR_EN_LO, A_STR_EN_HI, A_MASK_LO, A_MASK_HI: lsd_wmask = 8'hFF;
                A_SETUP, A_GSC_CTRL:                            lsd_wmask = 8'h8F;
                A_FAULT_EN:                                     lsd_wmask = 8'h3F;
                A_OSC:                                          lsd_wmask = 8'h07;
                A_OPT_A, 8'h11:                                 lsd_wmask = 8'hFF;
                A_OPT_C, A_DIM_B:                               lsd_wmask = 8'h0F;
                A_GSC_MUL, A_PHI_MUL:                           lsd_wmask = 8'h1F;
                A_PHI_CTRL:                                     lsd_wmask = 8'h87;
                8'h21, 8'h22, 8'h24, 8'h25, 8'h26:              lsd_wmask = 8'hFF;
                8'h28, 8'h29, 8'h2B, 8'h2C, A_DIM_A:            lsd_wmask = 8'hFF;
                8'h2F, 8'h30, 8'h31:                            lsd_wmask = 8'hFF;
                default:                                        lsd_wmask = 8'h00;
            endcase
        end
    endfunction : lsd_wmask

endpackage : lsd_pkg

/* lsd_reg_bank.sv */
//
// Contract
// - Control and status registers decode in 0x00 to 0xBF; gaps unused.
// - Registers 0xC0 and 0xC1 give host access to nonvolatile storage.
// - Nonvolatile storage holds every control register power-up default.
// - Host may overwrite stored defaults through the access registers.
// - Enable rise boot-loads storage into registers and clears all fault flags.
// - Enable low ignores serial traffic, stops optimizer, turns strings off.
// - Engine-on plus passthrough bits drive strings straight from external duty input.
`timescale 1ns/1ps
module lsd_reg_bank (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       enable_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_wr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic       ext_duty_in,
    input  wire logic [15:0] engine_duty_in,
    input  wire logic [7:0] fault_set_in,
    input  wire logic [15:0] open_set_in,
    input  wire logic [15:0] short_set_in,
    input  wire logic [7:0] dac_one_in,
    input  wire logic [7:0] dac_two_in,
    input  wire logic [7:0] dac_three_in,
    input  wire logic [7:0] optimizer_state_in,
    input  wire logic [7:0] dimming_state_in,
    input  wire logic [7:0] frame_pulse_count_in,
    input  wire logic [12:0] gray_pulse_count_in,
    input  wire logic [7:0] ctrl_addr_in,
    output logic      [7:0] ctrl_data_out,
    output logic      [15:0] string_drive_out,
    output logic      optimizer_on_out,
    output logic      boot_active_out
);
    import lsd_pkg::*;

    // =========================================================================
    // Pin synchronisers
    logic       en_meta_reg;
    logic       en_sync_reg;
    logic       en_prev_reg;
    logic       duty_meta_reg;
    logic       duty_sync_reg;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            en_meta_reg   <= 1'b0;
            en_sync_reg   <= 1'b0;
            en_prev_reg   <= 1'b0;
            duty_meta_reg <= 1'b0;
            duty_sync_reg <= 1'b0;
        end else begin
            en_meta_reg   <= enable_in;
            en_sync_reg   <= en_meta_reg;
            en_prev_reg   <= en_sync_reg;
            duty_meta_reg <= ext_duty_in;
            duty_sync_reg <= duty_meta_reg;
        end
    end

    wire en_rise = en_sync_reg && !en_prev_reg;

    // =========================================================================
    // State
    lsd_state_t state_reg;
    lsd_state_t state_next;
    logic [7:0] boot_idx_reg;
    logic [7:0] boot_idx_next;
    logic [7:0] nv_ptr_reg;
    logic       nv_err_reg;
    logic       nv_err_next;
    logic [7:0] ctrl_mem [CTRL_SPAN];
    logic [7:0] fault_sum_reg;
    logic [15:0] open_flags_reg;
    logic [15:0] short_flags_reg;

    lsd_nv_if nv_bus ();

    lsd_nv_store #(.DEPTH(CTRL_SPAN)) u_store (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .nv       (nv_bus)
    );

    // =========================================================================
    // Host access decode
    // Host writes during a boot load are dropped so a half-loaded image never mixes with host data.
    wire        host_live  = en_sync_reg && state_reg == LSD_IDLE;
    wire        host_wr    = host_live && reg_wr_in;
    wire        in_ctrl    = reg_addr_in <= A_CTRL_LAST;
    wire [7:0]  host_mask  = in_ctrl ? lsd_wmask(reg_addr_in) : 8'h00;
    wire        ctrl_wr    = host_wr && host_mask != 8'h00;
    wire        ptr_wr     = host_wr && reg_addr_in == A_NV_PTR;
    wire        cmd_wr     = host_wr && reg_addr_in == A_NV_CMD;
    wire [2:0]  cmd_code   = reg_wdata_in[2:0];
    wire        ptr_ok     = nv_ptr_reg <= A_CTRL_LAST && lsd_wmask(nv_ptr_reg) != 8'h00;
    wire        load_go    = cmd_wr && cmd_code == NV_CMD_LOAD && ptr_ok;
    wire        store_go   = cmd_wr && cmd_code == NV_CMD_STORE && ptr_ok;
    wire        boot_cmd   = cmd_wr && cmd_code == NV_CMD_BOOT;
    wire        cmd_bad    = cmd_wr && (cmd_code == NV_CMD_LOAD || cmd_code == NV_CMD_STORE)
                             && !ptr_ok;
    wire        boot_start = en_rise || boot_cmd;
    wire [7:0]  boot_mask  = lsd_wmask(boot_idx_reg);

    assign nv_bus.rd_addr = (state_reg == LSD_BOOT) ? boot_idx_reg : nv_ptr_reg;
    assign nv_bus.wr_en   = store_go;
    assign nv_bus.wr_addr = nv_ptr_reg;
    assign nv_bus.wr_data = ctrl_mem[nv_ptr_reg];

    // =========================================================================
    // Control store write port
    wire        mem_we    = (state_reg == LSD_BOOT) || ctrl_wr || load_go;
    wire [7:0]  mem_waddr = (state_reg == LSD_BOOT) ? boot_idx_reg :
                            load_go ? nv_ptr_reg : reg_addr_in;
    wire [7:0]  mem_wdata = (state_reg == LSD_BOOT) ? (nv_bus.rd_data & boot_mask) :
                            load_go ? (nv_bus.rd_data & lsd_wmask(nv_ptr_reg)) :
                            (reg_wdata_in & host_mask);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < CTRL_SPAN; i++) begin
                ctrl_mem[i] <= 8'h00;
            end
        end else if (mem_we) begin
            ctrl_mem[mem_waddr] <= mem_wdata;
        end
    end

    // =========================================================================
    // Boot sequencer
    // The load walks the whole control range once, so it always takes the full span.
    always_comb begin
        state_next    = state_reg;
        boot_idx_next = boot_idx_reg;
        case (state_reg)
            LSD_IDLE: begin
                if (boot_start) begin
                    state_next    = LSD_BOOT;
                    boot_idx_next = 8'h00;
                end
            end
            LSD_BOOT: begin
                if (boot_idx_reg == A_CTRL_LAST) begin
                    state_next = LSD_IDLE;
                end else begin
                    boot_idx_next = boot_idx_reg + 8'h01;
                end
            end
            default: begin
                state_next = LSD_IDLE;
            end
        endcase
    end

    always_comb begin
        nv_err_next = nv_err_reg;
        if (cmd_bad)
            nv_err_next = 1'b1;
        else if (load_go || store_go || boot_cmd)
            nv_err_next = 1'b0;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_reg    <= LSD_IDLE;
            boot_idx_reg <= 8'h00;
            nv_ptr_reg   <= 8'h00;
            nv_err_reg   <= 1'b0;
        end else begin
            state_reg    <= state_next;
            boot_idx_reg <= boot_idx_next;
            nv_err_reg   <= nv_err_next;
            if (ptr_wr) begin
                nv_ptr_reg <= reg_wdata_in;
            end
        end
    end

    // =========================================================================
    // Sticky fault flags
    // A new event in the clearing cycle survives, but at power-on open and short events are masked off until the boot load sets A_MASK_LO and A_MASK_HI.
    wire [15:0] str_mask   = {ctrl_mem[A_MASK_HI], ctrl_mem[A_MASK_LO]};
    wire [7:0]  fault_sets = fault_set_in & FAULT_SUM_MASK;
    wire [15:0] open_sets  = open_set_in & str_mask;
    wire [15:0] short_sets = short_set_in & str_mask;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            fault_sum_reg   <= 8'h00;
            open_flags_reg  <= 16'h0000;
            short_flags_reg <= 16'h0000;
        end else begin
            fault_sum_reg   <= (en_rise ? 8'h00 : fault_sum_reg) | fault_sets;
            open_flags_reg  <= (en_rise ? 16'h0000 : open_flags_reg) | open_sets;
            short_flags_reg <= (en_rise ? 16'h0000 : short_flags_reg) | short_sets;
        end
    end

    // =========================================================================
    // Read path
    wire [7:0] nv_status = {state_reg == LSD_BOOT, state_reg == LSD_BOOT, nv_err_reg, 5'h00};
    wire [7:0] ro_data =
        (reg_addr_in == A_FAULT_SUM)   ? fault_sum_reg :
        (reg_addr_in == A_OC_LO)       ? open_flags_reg[7:0] :
        (reg_addr_in == A_OC_HI)       ? open_flags_reg[15:8] :
        (reg_addr_in == A_SC_LO)       ? short_flags_reg[7:0] :
        (reg_addr_in == A_SC_HI)       ? short_flags_reg[15:8] :
        (reg_addr_in == A_DAC1)        ? dac_one_in :
        (reg_addr_in == A_DAC2)        ? dac_two_in :
        (reg_addr_in == A_DAC3)        ? dac_three_in :
        (reg_addr_in == A_OPT_STATE)   ? optimizer_state_in :
        (reg_addr_in == A_DIM_STATE)   ? dimming_state_in :
        (reg_addr_in == A_PHI_PCNT)    ? frame_pulse_count_in :
        (reg_addr_in == A_GSC_PCNT_LO) ? gray_pulse_count_in[7:0] :
        (reg_addr_in == A_GSC_PCNT_HI) ? {3'h0, gray_pulse_count_in[12:8]} :
        (reg_addr_in == A_NV_PTR)      ? nv_ptr_reg :
        (reg_addr_in == A_NV_CMD)      ? nv_status : 8'h00;
    wire [7:0] rd_value = !en_sync_reg ? 8'h00 :
                          (in_ctrl && host_mask != 8'h00) ? ctrl_mem[reg_addr_in] : ro_data;

    // =========================================================================
    // String and optimizer drive
    // The duty pin passes two flops first, trading two cycles of lag for safe sampling.
    wire [15:0] str_en     = {ctrl_mem[A_STR_EN_HI], ctrl_mem[A_STR_EN_LO]};
    wire        engine_on  = ctrl_mem[A_DIM_A][DIM_ENGINE_BIT];
    wire        passthru   = engine_on && ctrl_mem[A_DIM_A][DIM_PASS_BIT];
    wire [15:0] duty_src   = passthru ? {16{duty_sync_reg}} : engine_duty_in;
    wire        drive_ok   = en_sync_reg && state_reg == LSD_IDLE && engine_on;
    wire [15:0] drive_next = drive_ok ? (str_en & duty_src) : 16'h0000;
    wire        opt_next   = en_sync_reg && ctrl_mem[A_OPT_C][OPT_EN_BIT];

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out    <= 8'h00;
            ctrl_data_out    <= 8'h00;
            string_drive_out <= 16'h0000;
            optimizer_on_out <= 1'b0;
            boot_active_out  <= 1'b0;
        end else begin
            if (reg_rd_in) begin
                reg_rdata_out <= rd_value;
            end
            ctrl_data_out    <= (ctrl_addr_in <= A_CTRL_LAST) ? ctrl_mem[ctrl_addr_in] : 8'h00;
            string_drive_out <= drive_next;
            optimizer_on_out <= opt_next;
            boot_active_out  <= state_next == LSD_BOOT;
        end
    end

    // =========================================================================
    // Assertions
    // Checks look one cycle after their cause, except a_store_writes_ptr, which checks the unregistered store strobe in the same cycle.
    wire gap_hit = reg_addr_in > A_SC_HI && reg_addr_in < A_OSC;

    a_gap_reads_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        reg_rd_in && gap_hit |=> reg_rdata_out == 8'h00)
        else $error("Unused address did not read zero.");

    a_pointer_readback: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ptr_wr ##1 !ptr_wr ##1 (reg_rd_in && reg_addr_in == A_NV_PTR && en_sync_reg)
        |=> reg_rdata_out == $past(reg_wdata_in, 3))
        else $error("Pointer did not read back its written value.");

    a_boot_copies_store: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state_reg == LSD_BOOT
        |=> ctrl_mem[$past(boot_idx_reg)] == ($past(nv_bus.rd_data) & $past(boot_mask)))
        else $error("Boot load did not copy the stored byte.");

    a_store_writes_ptr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cmd_wr && cmd_code == NV_CMD_STORE
        |-> (ptr_ok && nv_bus.wr_en && nv_bus.wr_addr == nv_ptr_reg)
            or (!ptr_ok && !nv_bus.wr_en ##1 nv_err_reg))
        else $error("Store command misbehaved.");

    a_rise_boots_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        en_rise && fault_sets == 8'h00 && open_sets == 16'h0000
        |=> fault_sum_reg == 8'h00 && open_flags_reg == 16'h0000
            && state_reg == LSD_BOOT ##191 state_reg == LSD_BOOT ##1 state_reg == LSD_IDLE)
        else $error("Enable rise did not clear faults and boot for the full span.");

    a_disabled_dark: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !en_sync_reg |=> string_drive_out == 16'h0000 && !optimizer_on_out
                         && ctrl_mem[$past(reg_addr_in)] == $past(ctrl_mem[reg_addr_in]))
        else $error("Disabled device drove strings or took a write.");

    a_direct_passthru: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        passthru && drive_ok
        |=> string_drive_out == ($past(str_en) & {16{$past(duty_sync_reg)}}))
        else $error("Passthrough did not follow the external duty input.");

    a_ro_write_kept: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        reg_wr_in && reg_addr_in == A_FAULT_SUM && fault_sets == 8'h00 && !en_rise
        |=> fault_sum_reg == $past(fault_sum_reg))
        else $error("Write altered a read-only flag register.");

    a_open_set_wins: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        open_sets != 16'h0000 |=> (open_flags_reg & $past(open_sets)) == $past(open_sets))
        else $error("Open fault event was lost.");

    a_ctrl_port_high: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ctrl_addr_in > A_CTRL_LAST |=> ctrl_data_out == 8'h00)
        else $error("Control port read above the range was not zero.");

    a_load_copies_store: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        load_go |=> ctrl_mem[$past(nv_ptr_reg)]
                    == ($past(nv_bus.rd_data) & lsd_wmask($past(nv_ptr_reg))))
        else $error("Load did not copy the stored byte.");

    a_bad_cmd_flags: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cmd_bad |=> nv_err_reg)
        else $error("Refused command did not raise the error bit.");

    a_boot_blocks_host: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state_reg == LSD_BOOT && reg_wr_in && reg_addr_in == A_NV_PTR
        |=> nv_ptr_reg == $past(nv_ptr_reg))
        else $error("Host write landed during a boot load.");

    // =========================================================================
    // Covers
    c_nv_refused: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        cmd_bad);
    c_boot_done: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        state_reg == LSD_BOOT ##1 state_reg == LSD_IDLE);
    c_store_done: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        store_go);
    c_passthru_on: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        passthru && drive_ok && duty_sync_reg);
    c_fault_seen: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        open_sets != 16'h0000);

endmodule : lsd_reg_bank

/* lsd_reg_bank_tb.sv */
`timescale 1ns/1ps
module lsd_reg_bank_tb;
    import lsd_pkg::*;
    logic        clk, rst_n, en, ext, wr, rd, opt_on, boot;
    logic [15:0] duty, opn, sht, drv;
    logic [7:0]  addr, wdat, rdat, fset, dac1, ostate, caddr, cdata, v;
    logic [12:0] gpc;
    int          mismatches, samples_checked, cycles;
    lsd_host_model host (.clk_in(clk), .rdata_in(rdat), .addr_out(addr),
        .wr_out(wr), .wdata_out(wdat), .rd_out(rd));
    lsd_reg_bank uut (.clk_in(clk), .rst_n_in(rst_n), .enable_in(en),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdat), .reg_rd_in(rd),
        .reg_rdata_out(rdat), .ext_duty_in(ext), .engine_duty_in(duty),
        .fault_set_in(fset), .open_set_in(opn), .short_set_in(sht),
        .dac_one_in(dac1), .dac_two_in(8'h00), .dac_three_in(8'h00),
        .optimizer_state_in(ostate), .dimming_state_in(8'h00),
        .frame_pulse_count_in(8'h00), .gray_pulse_count_in(gpc),
        .ctrl_addr_in(caddr), .ctrl_data_out(cdata), .string_drive_out(drv),
        .optimizer_on_out(opt_on), .boot_active_out(boot));
    // ============================================================
    // Shared tasks.
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rchk(logic [7:0] a, logic [7:0] exp);
        host.get(a, v);
        check($sformatf("reg %h", a), v, exp);
    endtask : rchk
    task automatic wait_boot();
        int n;
        n = 0;
        repeat (8) @(negedge clk);
        check("boot busy", boot, 1'h1);
        while (boot !== 1'h0 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check("boot done", n < 400, 1'h1);
    endtask : wait_boot
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    // ============================================================
    // Scenarios.
    task automatic t_defaults();
        rchk(8'h00, 8'hFF);
        rchk(8'h02, 8'h0D);
        rchk(8'h0F, 8'h04);
        rchk(8'h10, 8'h49);
        check("ctrl data", cdata, 8'h0D);
        caddr = 8'hC5;
        repeat (2) @(negedge clk);
        check("ctrl data high", cdata, 8'h00);
        caddr = 8'h02;
        $display("done defaults");
    endtask : t_defaults
    task automatic t_access();
        host.put(8'h31, 8'hA5);
        rchk(8'h31, 8'hA5);
        dac1 = 8'h5A;
        host.put(8'h13, 8'h00);
        rchk(8'h13, 8'h5A);
        host.put(8'h0B, 8'hFF);
        rchk(8'h0B, 8'h00);
        host.put(8'h06, 8'hFF);
        rchk(8'h06, 8'h00);
        gpc = 13'h1ABC;
        ostate = 8'h3C;
        host.put(8'h35, 8'hFF);
        rchk(8'h35, 8'h1A);
        rchk(8'h34, 8'hBC);
        rchk(8'h16, 8'h3C);
        $display("done access");
    endtask : t_access
    task automatic t_nv();
        host.put(8'h31, 8'h3C);
        host.save(8'h31);
        host.put(8'h31, 8'h00);
        host.put(8'hC1, 8'h01);
        rchk(8'h31, 8'h3C);
        host.put(8'hC0, 8'h06);
        rchk(8'hC0, 8'h06);
        host.put(8'hC1, 8'h01);
        rchk(8'hC1, 8'h20);
        $display("done nonvolatile");
    endtask : t_nv
    task automatic t_strings();
        host.put(8'h2D, 8'h03);
        ext = 1'h1;
        repeat (5) @(negedge clk);
        check("drive ext high", drv, 16'hFFFF);
        ext = 1'h0;
        repeat (5) @(negedge clk);
        check("drive ext low", drv, 16'h0000);
        host.put(8'h2D, 8'h01);
        duty = 16'h1234;
        host.put(8'h12, 8'h01);
        repeat (2) @(negedge clk);
        check("drive engine", drv, 16'h1234);
        check("optimizer on", opt_on, 1'h1);
        $display("done strings");
    endtask : t_strings
    task automatic t_enable();
        opn = 16'h0001;
        sht = 16'h8000;
        fset = 8'hFF;
        @(negedge clk);
        opn = 16'h0000;
        sht = 16'h0000;
        fset = 8'h00;
        rchk(8'h07, 8'h01);
        rchk(8'h0A, 8'h80);
        rchk(8'h06, FAULT_SUM_MASK);
        en = 1'h0;
        repeat (4) @(negedge clk);
        check("drive off", drv, 16'h0000);
        check("optimizer off", opt_on, 1'h0);
        host.put(8'h2F, 8'h77);
        rchk(8'h2F, 8'h00);
        en = 1'h1;
        repeat (4) @(negedge clk);
        host.put(8'hC0, 8'h55);
        wait_boot();
        rchk(8'hC0, 8'h06);
        rchk(8'h06, 8'h00);
        rchk(8'h07, 8'h00);
        rchk(8'h0A, 8'h00);
        rchk(8'h31, 8'h3C);
        rchk(8'h2F, 8'h00);
        $display("done enable");
    endtask : t_enable
    initial begin
        {ext, duty, opn, sht, fset, dac1, ostate, gpc} = '0;
        caddr = 8'h02;
        en = 1'h1;
        rst_n = 1'h0;
        repeat (8) @(negedge clk);
        rst_n = 1'h1;
        wait_boot();
        t_defaults();
        t_access();
        t_nv();
        t_strings();
        t_enable();
        report_and_stop();
    end
endmodule : lsd_reg_bank_tb
